// ==== fpu_branch_if.sv ====
/*
 * Carries a branch request from the decoder to the branch unit.
 * Assumes a single clock domain.
 */
interface fpu_branch_if;
  logic        valid;
  logic        want_true;
  logic        likely;
  logic [15:0] offset;
  logic [31:0] slot_pc;
  logic        taken;
  logic        nullify;
  logic [31:0] target;

  modport dec (output valid, output want_true, output likely, output offset, output slot_pc,
               input taken, input nullify, input target);
  modport unit (input valid, input want_true, input likely, input offset, input slot_pc,
                output taken, output nullify, output target);
endinterface

// ==== fpu_branch_unit.sv ====
/*
 * Floating-point branch resolution: target, taken decision, nullify.
 * Assumes the compare flag is driven from the datapath each cycle.
 */
module fpu_branch_unit (
  input  wire logic  core_clk,
  input  wire logic  reset,
  input  wire logic  compare_result_flag,
  fpu_branch_if.unit br
);
  import fpu_decode_pkg::*;

  logic        cond_r;
  logic        cond_nxt;
  logic [31:0] ofs_ext;

  //////////////////////////////////////////////////////////////////////////////
  // Flag sampled one stage ahead of target formation
  assign cond_nxt = compare_result_flag;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cond_r <= 1'b0;
    end else begin
      cond_r <= cond_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Target and decision
  assign ofs_ext    = {{14{br.offset[15]}}, br.offset, 2'b00};
  assign br.target  = br.slot_pc + ofs_ext;
  assign br.taken   = br.valid && (cond_r == br.want_true);
  assign br.nullify = br.valid && br.likely && !br.taken;

endmodule

// ==== fpu_datapath_model.sv ====
/*
 * Far-side model of the arithmetic datapath that answers the decoder.
 * Assumes the bench chooses the flag and NaN values and holds them per cycle.
 */
module fpu_datapath_model
  import fpu_decode_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   op_valid,
  input  wire fpu_decode_pkg::fp_op_e op_code,
  input  wire logic [3:0]             flags_cfg,
  input  wire logic                   nan_cfg,
  output logic [3:0]                  add_flags,
  output logic                        src_is_nan
);
  timeunit 1ns;
  timeprecision 1ps;
  logic op_valid_r;

  ////////////////////////////////////////////////////////////////////////
  // Remember an issue so the NaN answer covers the following cycle too
  always_ff @(posedge core_clk) begin
    op_valid_r <= reset ? 1'b0 : op_valid;
  end

  // Outside its answer window each line shows the inverse, never a stale value
  assign add_flags  = (op_valid && op_code == OP_ADD) ? flags_cfg : ~flags_cfg;
  assign src_is_nan = (op_valid || op_valid_r) ? nan_cfg : ~nan_cfg;
endmodule

// ==== fpu_decode_defines.svh ====
/*
 * Field positions, format codes, function codes and branch codes for the
 * floating-point coprocessor decoder.
 * Assumes 32-bit instruction words with the opcode in bits 31..26.
 */
`ifndef FPU_DECODE_DEFINES_SVH
`define FPU_DECODE_DEFINES_SVH

`define OPC_FP_COPROC   6'h11
`define SUB_BRANCH      5'h08
`define BR_COND_FALSE   5'h00
`define BR_COND_TRUE    5'h01
`define BR_COND_FALSE_L 5'h02
`define BR_COND_TRUE_L  5'h03
`define FMT_SINGLE      5'h10
`define FMT_DOUBLE      5'h11
`define FMT_WORD        5'h14
`define FMT_LONG        5'h15
`define FN_ADD          6'h00
`define FN_NEG          6'h07
`define FN_LONG_LO      6'h08
`define FN_LONG_HI      6'h0b
`define FN_WORD_LO      6'h0c
`define FN_WORD_HI      6'h0f
`define FN_CONV_SINGLE  6'h20
`define FN_CONV_DOUBLE  6'h21
`define FN_CONV_WORD    6'h24
`define FN_CONV_LONG    6'h25
`define FN_CMP_LO       6'h30
`define STATUS_WIDTH_BIT 26

`endif

// ==== fpu_decode_pkg.sv ====
/*
 * Types shared by the floating-point decoder modules.
 * Assumes the defines header is compiled alongside.
 */
package fpu_decode_pkg;

  typedef enum logic [3:0] {
    OP_ADD    = 4'b0000,
    OP_SUB    = 4'b0001,
    OP_MUL    = 4'b0010,
    OP_DIV    = 4'b0011,
    OP_SQRT   = 4'b0100,
    OP_ABS    = 4'b0101,
    OP_MOV    = 4'b0110,
    OP_NEG    = 4'b0111,
    OP_CONV_TO_WORD_FIXED  = 4'b1000,
    OP_CONV_TO_SINGLE_FLOAT  = 4'b1001,
    OP_CMP    = 4'b1010,
    OP_NONE   = 4'b1111
  } fp_op_e;

  typedef enum logic [1:0] {
    RND_NEAREST = 2'b00,
    RND_ZERO    = 2'b01,
    RND_PLUS    = 2'b10,
    RND_MINUS   = 2'b11
  } round_mode_e;

endpackage

// ==== fpu_instruction_decode.sv ====
/*
 * Decoder for floating-point coprocessor instructions.
 * Assumes instructions arrive with a valid strobe synchronous to core_clk,
 * and the status word and compare flag come from the core.
 */
// How it works
// - Format field: 16 single, 17 double, 20 word, 21 long; others reserved.
// - Double format and long codes 8-11, 33, 37 trap as unimplemented.
// - Function codes 0-7 map to add through negate in order.
// - Codes 12-15 convert to word, rounding fixed per code.
// - Code 32 converts to single float.
// - Code 36 converts to 32-bit fixed word.
// - Code 37, convert to long, traps.
// - Codes 48-63 are compares, low bits choose condition.
// - Width bit zero: only even registers valid.
// - Width bit one: odd and even registers valid.
// - Width bit zero with odd specifier gives undefined result.
// - Width bit zero: double access to odd register undefined.
// - Absolute value is arithmetic; NaN source signals invalid.
// - Add rounds with current mode and writes destination.
// - Add may flag invalid, inexact, overflow, underflow, unimplemented.
// - Branch target is slot address plus offset shifted two, sign-extended.
// - Branch-false taken only when last compare false.
// - Branch-true taken only when last compare true.
// - Likely branches nullify the delay slot when not taken.
// - Branch recognised by opcode 010001, sub-opcode 01000, condition field.
// - Coprocessor disabled raises unusable; otherwise floating exceptions possible.
`include "fpu_decode_defines.svh"

module fpu_instruction_decode (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        instr_valid,
  input  wire logic [31:0]                 instr_word,
  input  wire logic [31:0]                 instr_pc,
  input  wire logic [31:0]                 processor_status_reg,
  input  wire logic                        coproc_enable,
  input  wire logic                        compare_result_flag,
  input  wire logic [1:0]                  current_round_mode,
  input  wire logic                        src_is_nan,
  input  wire logic [3:0]                  add_flags,
  output logic                             op_valid,
  output fpu_decode_pkg::fp_op_e           op_code,
  output logic [4:0]                       op_format,
  output logic [4:0]                       src_reg,
  output logic [4:0]                       tgt_reg,
  output logic [4:0]                       dst_reg,
  output fpu_decode_pkg::round_mode_e      op_round,
  output logic [3:0]                       cmp_cond,
  output logic                             reg_write_en,
  output logic                             unimpl_trap,
  output logic                             coproc_unusable,
  output logic                             undefined_operand,
  output logic                             invalid_flag,
  output logic                             inexact_flag,
  output logic                             overflow_flag,
  output logic                             underflow_flag,
  output logic                             branch_valid,
  output logic                             branch_taken,
  output logic                             branch_nullify,
  output logic [31:0]                      branch_target
);
  import fpu_decode_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Field extraction
  wire logic [5:0] opc    = instr_word[31:26];
  wire logic [4:0] fmt    = instr_word[25:21];
  wire logic [4:0] ft     = instr_word[20:16];
  wire logic [4:0] fs     = instr_word[15:11];
  wire logic [4:0] fd     = instr_word[10:6];
  wire logic [5:0] fn     = instr_word[5:0];
  wire logic       is_cop = instr_valid && (opc == `OPC_FP_COPROC);
  wire logic       width_mode_bit = processor_status_reg[`STATUS_WIDTH_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Branch recognition
  wire logic is_branch  = is_cop && (fmt == `SUB_BRANCH);
  wire logic br_f       = (ft == `BR_COND_FALSE);
  wire logic br_t       = (ft == `BR_COND_TRUE);
  wire logic br_fl      = (ft == `BR_COND_FALSE_L);
  wire logic br_tl      = (ft == `BR_COND_TRUE_L);
  wire logic br_known   = br_f || br_t || br_fl || br_tl;
  wire logic br_go      = is_branch && br_known && coproc_enable;

  //////////////////////////////////////////////////////////////////////////////
  // Format decode
  wire logic fmt_s      = (fmt == `FMT_SINGLE);
  wire logic fmt_d      = (fmt == `FMT_DOUBLE);
  wire logic fmt_w      = (fmt == `FMT_WORD);
  wire logic fmt_l      = (fmt == `FMT_LONG);
  wire logic fmt_legal  = fmt_s || fmt_w;
  wire logic is_arith   = is_cop && (fmt[4] == 1'b1);

  //////////////////////////////////////////////////////////////////////////////
  // Function decode
  wire logic fn_basic   = (fn <= `FN_NEG);
  wire logic fn_long    = (fn >= `FN_LONG_LO) && (fn <= `FN_LONG_HI);
  wire logic fn_word    = (fn >= `FN_WORD_LO) && (fn <= `FN_WORD_HI);
  wire logic fn_conv_to_single_float   = (fn == `FN_CONV_SINGLE);
  wire logic fn_conv_to_double_float   = (fn == `FN_CONV_DOUBLE);
  wire logic fn_conv_to_word_fixed   = (fn == `FN_CONV_WORD);
  wire logic fn_conv_to_long_fixed   = (fn == `FN_CONV_LONG);
  wire logic fn_cmp     = (fn >= `FN_CMP_LO);
  wire logic fn_legal   = fn_basic || fn_word || fn_conv_to_single_float || fn_conv_to_word_fixed || fn_cmp;

  // Unimplemented: double, long, reserved format or function
  wire logic trap_now   = is_arith && coproc_enable &&
                          (fmt_d || fmt_l || !fmt_legal || fn_long || fn_conv_to_double_float || fn_conv_to_long_fixed || !fn_legal);
  wire logic unusable   = (is_arith || is_branch) && !coproc_enable;
  wire logic exec_now   = is_arith && coproc_enable && !trap_now;

  // Odd specifier with narrow register mode
  wire logic odd_spec   = fs[0] || ft[0] || fd[0];
  wire logic undef_now  = exec_now && !width_mode_bit && odd_spec;

  //////////////////////////////////////////////////////////////////////////////
  // Operation selection
  fp_op_e      op_nxt;
  round_mode_e rnd_nxt;
  always_comb begin
    op_nxt  = OP_NONE;
    rnd_nxt = round_mode_e'(current_round_mode);
    if (fn_basic) begin
      op_nxt = fp_op_e'({1'b0, fn[2:0]});
    end else if (fn_word) begin
      op_nxt  = OP_CONV_TO_WORD_FIXED;
      rnd_nxt = round_mode_e'(fn[1:0]);
    end else if (fn_conv_to_word_fixed) begin
      op_nxt = OP_CONV_TO_WORD_FIXED;
    end else if (fn_conv_to_single_float) begin
      op_nxt = OP_CONV_TO_SINGLE_FLOAT;
    end else if (fn_cmp) begin
      op_nxt = OP_CMP;
    end
  end

  wire logic writes_dst = exec_now && (op_nxt != OP_CMP);

  //////////////////////////////////////////////////////////////////////////////
  // Arithmetic condition flags, one cycle behind the issued op
  wire logic prev_abs  = op_valid && (op_code == OP_ABS);
  wire logic prev_add  = op_valid && (op_code == OP_ADD);
  wire logic inv_nxt   = (prev_abs && src_is_nan) || (prev_add && add_flags[0]);
  wire logic inx_nxt   = prev_add && add_flags[1];
  wire logic ovf_nxt   = prev_add && add_flags[2];
  wire logic unf_nxt   = prev_add && add_flags[3];

  //////////////////////////////////////////////////////////////////////////////
  // Branch unit
  fpu_branch_if bri ();
  assign bri.valid     = br_go;
  assign bri.want_true = br_t || br_tl;
  assign bri.likely    = br_fl || br_tl;
  assign bri.offset    = instr_word[15:0];
  assign bri.slot_pc   = instr_pc + 32'h0000_0004;

  fpu_branch_unit u_branch (
    .core_clk            (core_clk),
    .reset               (reset),
    .compare_result_flag (compare_result_flag),
    .br                  (bri)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      op_valid          <= 1'b0;
      op_code           <= OP_NONE;
      op_format         <= 5'h00;
      src_reg           <= 5'h00;
      tgt_reg           <= 5'h00;
      dst_reg           <= 5'h00;
      op_round          <= RND_NEAREST;
      cmp_cond          <= 4'h0;
      reg_write_en      <= 1'b0;
      unimpl_trap       <= 1'b0;
      coproc_unusable   <= 1'b0;
      undefined_operand <= 1'b0;
      invalid_flag      <= 1'b0;
      inexact_flag      <= 1'b0;
      overflow_flag     <= 1'b0;
      underflow_flag    <= 1'b0;
      branch_valid      <= 1'b0;
      branch_taken      <= 1'b0;
      branch_nullify    <= 1'b0;
      branch_target     <= 32'h0000_0000;
    end else begin
      op_valid          <= exec_now;
      op_code           <= exec_now ? op_nxt : OP_NONE;
      op_format         <= fmt;
      src_reg           <= fs;
      tgt_reg           <= ft;
      dst_reg           <= fd;
      op_round          <= rnd_nxt;
      cmp_cond          <= fn[3:0];
      reg_write_en      <= writes_dst;
      unimpl_trap       <= trap_now;
      coproc_unusable   <= unusable;
      undefined_operand <= undef_now;
      invalid_flag      <= inv_nxt;
      inexact_flag      <= inx_nxt;
      overflow_flag     <= ovf_nxt;
      underflow_flag    <= unf_nxt;
      branch_valid      <= br_go;
      branch_taken      <= bri.taken;
      branch_nullify    <= bri.nullify;
      branch_target     <= bri.target;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_trap_double;
    @(posedge core_clk) disable iff (reset)
      (is_cop && coproc_enable && fmt_d && fmt[4]) |=> unimpl_trap && !op_valid;
  endproperty
  a_trap_double: assert property (p_trap_double) else $error("double format did not trap");

  property p_basic_op;
    @(posedge core_clk) disable iff (reset)
      (exec_now && fn_basic) |=> (op_code == fp_op_e'({1'b0, $past(fn[2:0])}));
  endproperty
  a_basic_op: assert property (p_basic_op) else $error("basic op code wrong");

  property p_word_round;
    @(posedge core_clk) disable iff (reset)
      (exec_now && fn_word) |=> (op_code == OP_CONV_TO_WORD_FIXED) && (op_round == round_mode_e'($past(fn[1:0])));
  endproperty
  a_word_round: assert property (p_word_round) else $error("word rounding wrong");

  property p_cmp;
    @(posedge core_clk) disable iff (reset)
      (exec_now && fn_cmp) |=> (op_code == OP_CMP) && !reg_write_en;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare decode wrong");

  property p_even_only;
    @(posedge core_clk) disable iff (reset)
      (exec_now && !width_mode_bit && fd[0]) |=> undefined_operand;
  endproperty
  a_even_only: assert property (p_even_only) else $error("odd register not flagged");

  property p_wide_ok;
    @(posedge core_clk) disable iff (reset)
      (exec_now && width_mode_bit) |=> !undefined_operand;
  endproperty
  a_wide_ok: assert property (p_wide_ok) else $error("odd register wrongly flagged");

  property p_unusable;
    @(posedge core_clk) disable iff (reset)
      (is_cop && fmt[4] && !coproc_enable) |=> coproc_unusable && !op_valid && !unimpl_trap;
  endproperty
  a_unusable: assert property (p_unusable) else $error("unusable not raised");

  sequence s_cmp_seen(v);
    compare_result_flag == v;
  endsequence
  sequence s_branch_false;
    br_go && (br_f || br_fl);
  endsequence
  property p_branch_false;
    @(posedge core_clk) disable iff (reset)
      s_cmp_seen(1'b0) ##1 s_branch_false |=> branch_taken;
  endproperty
  a_branch_false: assert property (p_branch_false) else $error("false branch not taken");

  property p_branch_true;
    @(posedge core_clk) disable iff (reset)
      s_cmp_seen(1'b1) ##1 (br_go && br_t) |=> branch_taken && !branch_nullify;
  endproperty
  a_branch_true: assert property (p_branch_true) else $error("true branch not taken");

  property p_likely_null;
    @(posedge core_clk) disable iff (reset)
      s_cmp_seen(1'b1) ##1 (br_go && br_fl) |=> !branch_taken && branch_nullify;
  endproperty
  a_likely_null: assert property (p_likely_null) else $error("likely slot not nullified");

  property p_target;
    @(posedge core_clk) disable iff (reset)
      br_go |=> branch_target == $past(instr_pc) + 32'h0000_0004 +
                {{14{$past(instr_word[15])}}, $past(instr_word[15:0]), 2'b00};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_abs_nan;
    @(posedge core_clk) disable iff (reset)
      (op_valid && op_code == OP_ABS && src_is_nan) |=> invalid_flag;
  endproperty
  a_abs_nan: assert property (p_abs_nan) else $error("abs of NaN not invalid");

  property p_conv_long;
    @(posedge core_clk) disable iff (reset)
      (is_arith && coproc_enable && fn_conv_to_long_fixed) |=> unimpl_trap && !op_valid;
  endproperty
  a_conv_long: assert property (p_conv_long) else $error("long conversion did not trap");

  property p_conv_single;
    @(posedge core_clk) disable iff (reset)
      (exec_now && fn_conv_to_single_float) |=> (op_code == OP_CONV_TO_SINGLE_FLOAT) && reg_write_en;
  endproperty
  a_conv_single: assert property (p_conv_single) else $error("single conversion decode wrong");

  property p_add_flags;
    @(posedge core_clk) disable iff (reset)
      (op_valid && op_code == OP_ADD) |=>
        ({underflow_flag, overflow_flag, inexact_flag, invalid_flag} == $past(add_flags));
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add condition flags lost");

endmodule

// ==== fpu_instruction_decode_tb_top.sv ====
/*
 * Self-checking bench for the floating-point instruction decoder.
 * Assumes registered outputs one cycle after issue, flags two cycles after.
 */
module fpu_instruction_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fpu_decode_pkg::*;

  logic        core_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, coproc_enable = 1'b0;
  logic        compare_result_flag = 1'b0, nan_cfg = 1'b0, src_is_nan;
  logic [31:0] instr_word = 32'h0000_0000, instr_pc = 32'h0000_0000, status_word = 32'h0000_0000;
  logic [1:0]  current_round_mode = 2'h0;
  logic [3:0]  flags_cfg = 4'h0, add_flags, cmp_cond;
  logic [4:0]  op_format, src_reg, tgt_reg, dst_reg;
  logic        op_valid, reg_write_en, unimpl_trap, coproc_unusable, undefined_operand;
  logic        invalid_flag, inexact_flag, overflow_flag, underflow_flag;
  logic        branch_valid, branch_taken, branch_nullify;
  logic [31:0] branch_target, seed = 32'h0000_7a86;
  fp_op_e      op_code;
  round_mode_e op_round;
  int          error_cnt = 0, samples_checked = 0, cnt = 0;
  // Bench history: d1 issued one step ago, d2 two steps ago
  logic        d1_v = 1'b0, d1_en, d1_st, d1_fl, d2_go = 1'b0, d2_nok, d2_nan;
  logic [31:0] d1_w, d1_pc, d2_w;
  logic [1:0]  d1_rm;
  logic [3:0]  d2_cfg;

  always #5 core_clk = ~core_clk;

  fpu_instruction_decode u_dut (
    .core_clk(core_clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_pc(instr_pc), .processor_status_reg(status_word), .coproc_enable(coproc_enable),
    .compare_result_flag(compare_result_flag), .current_round_mode(current_round_mode),
    .src_is_nan(src_is_nan), .add_flags(add_flags), .op_valid(op_valid), .op_code(op_code),
    .op_format(op_format), .src_reg(src_reg), .tgt_reg(tgt_reg), .dst_reg(dst_reg),
    .op_round(op_round), .cmp_cond(cmp_cond), .reg_write_en(reg_write_en), .unimpl_trap(unimpl_trap),
    .coproc_unusable(coproc_unusable), .undefined_operand(undefined_operand),
    .invalid_flag(invalid_flag), .inexact_flag(inexact_flag), .overflow_flag(overflow_flag),
    .underflow_flag(underflow_flag), .branch_valid(branch_valid), .branch_taken(branch_taken),
    .branch_nullify(branch_nullify), .branch_target(branch_target));

  fpu_datapath_model u_dp (
    .core_clk(core_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .flags_cfg(flags_cfg), .nan_cfg(nan_cfg), .add_flags(add_flags), .src_is_nan(src_is_nan));

  ////////////////////////////////////////////////////////////////////////
  // Helpers: random source, comparison, verdict
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Reference decode of trap and operation class
  function automatic logic trap_of(input logic [31:0] w);
    int fn;
    fn = int'(w[5:0]);
    return !(w[25:21] == 5'h10 || w[25:21] == 5'h14) || (fn >= 8 && fn <= 11) ||
           (fn >= 16 && fn <= 31) || (fn >= 33 && fn <= 35) || (fn >= 37 && fn <= 47);
  endfunction

  function automatic logic [3:0] op_of(input int fn);
    if (fn < 8) return fn[3:0];
    if (fn == 32) return 4'ha - 4'h1;
    if (fn >= 48) return 4'ha;
    return 4'h8;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Compare the outputs of the last issue and the flags of the one before
  task automatic check_now();
    int   fn;
    logic tk;
    fn = int'(d1_w[5:0]);
    tk = d1_w[16] ? d1_fl : !d1_fl;
    if (!d1_v || d1_w[31:26] !== 6'h11) begin
      chk("op_valid", op_valid, 0);
      chk("branch_valid", branch_valid, 0);
      chk("coproc_unusable", coproc_unusable, 0);
      chk("unimpl_trap", unimpl_trap, 0);
    end else if (!d1_en) begin
      chk("coproc_unusable", coproc_unusable, 1);
      chk("op_valid", op_valid, 0);
      chk("branch_valid", branch_valid, 0);
    end else if (d1_w[25:21] == 5'h08) begin
      chk("branch_valid", branch_valid, 1);
      chk("branch_taken", branch_taken, tk);
      chk("branch_nullify", branch_nullify, d1_w[17] && !tk);
      chk("branch_target", branch_target, d1_pc + 32'h4 + {{14{d1_w[15]}}, d1_w[15:0], 2'b00});
    end else if (d1_w[25]) begin
      chk("unimpl_trap", unimpl_trap, trap_of(d1_w));
      if (!trap_of(d1_w)) begin
        chk("op_valid", op_valid, 1);
        chk("op_code", op_code, op_of(fn));
        chk("op_format", op_format, d1_w[25:21]);
        chk("regs", {src_reg, tgt_reg, dst_reg}, {d1_w[15:11], d1_w[20:16], d1_w[10:6]});
        chk("undefined_operand", undefined_operand, !d1_st && (d1_w[11] | d1_w[16] | d1_w[6]));
        chk("reg_write_en", reg_write_en, fn < 48);
        if (fn >= 12 && fn <= 15) chk("op_round", op_round, d1_w[1:0]);
        if (fn == 0) chk("op_round", op_round, d1_rm);
        if (fn >= 48) chk("cmp_cond", cmp_cond, d1_w[3:0]);
      end else begin
        chk("op_valid", op_valid, 0);
      end
    end
    if (d2_go && d2_w[5:0] == 6'h00)
      chk("add_flags", {underflow_flag, overflow_flag, inexact_flag, invalid_flag}, d2_cfg);
    if (d2_go && d2_w[5:0] == 6'h05 && d2_nok) chk("invalid_flag", invalid_flag, d2_nan);
  endtask

  // One cycle: check, shift history, drive the next issue
  task automatic step(input logic v, input logic [31:0] w, input logic [31:0] r);
    @(posedge core_clk);
    #1;
    check_now();
    cnt++;
    d2_go  = d1_v && d1_w[31:26] == 6'h11 && d1_en && d1_w[25] && !trap_of(d1_w);
    d2_w   = d1_w;
    d2_cfg = r[27:24];
    d2_nan = cnt[3];
    d2_nok = (cnt[3] == 1'(((cnt + 1) >> 3) & 1));
    {d1_v, d1_w, d1_pc, d1_en, d1_st} = {v, w, r[31:2], 2'b00, r[15:13] != 3'h0, r[20]};
    {d1_fl, d1_rm} = {compare_result_flag, r[23:22]};
    {instr_valid, instr_word, instr_pc, coproc_enable} = {v, w, d1_pc, d1_en};
    status_word = {5'h00, d1_st, 26'h000_0000};
    {compare_result_flag, current_round_mode, flags_cfg, nan_cfg} = {r[21], d1_rm, r[27:24], cnt[3]};
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, random issues back to back, a mid-run reset, flush
  initial begin
    logic [31:0] r, w;
    logic [4:0]  fmt;
    repeat (3) @(posedge core_clk);
    #1 reset = 1'b0;
    @(posedge core_clk);
    #1;
    chk("op_code", op_code, 4'hf);
    for (int i = 0; i < 600; i++) begin
      r   = xs();
      w   = xs();
      fmt = (r[1:0] == 2'h0) ? {1'b1, r[7:4]} : (r[2] ? 5'h14 : 5'h10);
      if (r[9:8] == 2'h0) w = {6'h11, 5'h08, 3'h0, r[17:16], w[15:0]};
      else if (r[12:10] == 3'h0) w = {6'h23, w[25:0]};
      else w = {6'h11, fmt, w[20:0]};
      step(r[30:29] != 2'h0, w, xs());
      // Reset lands on a live issue; its results and pending flags must vanish
      if (i == 300) begin
        reset = 1'b1;
        @(posedge core_clk);
        #1;
        chk("op_code", op_code, 4'hf);
        chk("reset_outs", {op_valid, reg_write_en, unimpl_trap, coproc_unusable, undefined_operand, invalid_flag,
                           inexact_flag, overflow_flag, underflow_flag, branch_valid, branch_taken,
                           branch_nullify}, 0);
        chk("branch_target", branch_target, 0);
        {d1_v, d2_go, instr_valid} = 3'b000;
        @(posedge core_clk);
        #1 reset = 1'b0;
      end
    end
    step(1'b0, 32'h0000_0000, 32'h0000_0000);
    step(1'b0, 32'h0000_0000, 32'h0000_0000);
    close_out();
  end
endmodule
